// ==== hdl/tcs_cfg.svh ====
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// ********************************************************
// Timing
// ********************************************************
`define TCS_CLK_PERIOD_NS 8
`define TCS_SAMPLE_NS     10000
`define TCS_SAMPLE_CYC    (`TCS_SAMPLE_NS / `TCS_CLK_PERIOD_NS)
`define TCS_NS_PER_MS     1000000
`define TCS_SMP_PER_MS    (`TCS_NS_PER_MS / `TCS_SAMPLE_NS)
`define TCS_TICK_W        11

// ********************************************************
// Register indices (byte address is four times the index)
// ********************************************************
`define TCS_IDX_MODE      10'h100
`define TCS_IDX_PRE1      10'h101
`define TCS_IDX_SMOOTH    10'h10E
`define TCS_IDX_FSCALE    10'h129
`define TCS_IDX_STATUS    10'h130
`define TCS_IDX_CMD       10'h131

// ********************************************************
// Reset values and limits
// ********************************************************
`define TCS_RST_SMOOTH    16'h0000
`define TCS_RST_FSCALE    16'h0064
`define TCS_RST_PRESET    16'h0000
`define TCS_SMOOTH_MAX    16'h03E8
`define TCS_FSCALE_MAX    16'h03E8
`define TCS_PRESET_MAX    16'h012C
`define TCS_NUM_PRESET    3
`define TCS_TQ_UNIT       32'sh0000000A
`define TCS_ADC_SHIFT     15
`define TCS_FRAC          16
`define TCS_COEF_ONE      17'h10000
`define TCS_DIV_STEPS     5'h10

// ********************************************************
// Status fields
// ********************************************************
`define TCS_ST_HELD_LSB   0
`define TCS_ST_SRC_LSB    2
`define TCS_ST_FILT       5
`define TCS_ST_BUSY       6
`define TCS_ST_TORQ       7

`endif

// ==== hdl/tcs_pkg.sv ====
package tcs_pkg;

	typedef enum logic [2:0] {
		TCS_PULSE_POS     = 3'h0,
		TCS_PRESET_POS    = 3'h1,
		TCS_SPEED         = 3'h2,
		TCS_ZERO_SPEED    = 3'h3,
		TCS_ANALOG_TORQUE = 3'h4,
		TCS_ZERO_TORQUE   = 3'h5
	} tcs_mode_type;

	typedef enum logic [2:0] {
		TCS_SRC_ZERO   = 3'b001,
		TCS_SRC_ANALOG = 3'b010,
		TCS_SRC_PRESET = 3'b100
	} tcs_src_type;

	typedef enum logic [2:0] {
		TCS_DIV_IDLE = 3'b001,
		TCS_DIV_RUN  = 3'b010,
		TCS_DIV_DONE = 3'b100
	} tcs_div_type;

endpackage

// ==== hdl/tcs_top.sv ====
// Notes on behaviour
// - Each select input reads one as contact on and zero as off.
// - Source follows both select inputs and the configured mode.
// - Selects at zero in zero-reference torque mode give exactly zero.
// - Selects at zero in analog torque mode use the +/-10 V reference.
// - Patterns 0,1 / 1,0 / 1,1 pick presets one / two / three.
// - Any nonzero select takes a preset held within -300 to 300 %.
// - A preset write takes effect at the next sample, a select change at the one after.
// - In position and speed modes the result is the torque limit.
// - Analog command passes a low-pass of 0..1000 ms, zero bypasses.
// - The smoothing acts only in analog torque mode.
// - Analog result is voltage times scaling percentage over ten.
// - Scaling is a 16-bit percentage of 0..1000, reset 100.
// - In torque mode scaling sets the command at 10 V input.
// - In position and speed modes scaling sets the limit at 10 V.
//
// The implementer's own choice: register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_top
	import tcs_pkg::*;
(
	input  wire logic               clk,               // Clock
	input  wire logic               rst,               // Async reset
	input  wire logic               wb_cyc_i,          // Bus cycle
	input  wire logic               wb_stb_i,          // Bus strobe
	input  wire logic               wb_we_i,           // Write enable
	input  wire logic [11:0]        wb_adr_i,          // Byte address
	input  wire logic [31:0]        wb_dat_i,          // Write data
	input  wire logic [3:0]         wb_sel_i,          // Byte enables
	output logic      [31:0]        wb_dat_o,          // Read data
	output logic                    wb_ack_o,          // Acknowledge
	input  wire logic               torque_select_bit0, // Select input 0
	input  wire logic               torque_select_bit1, // Select input 1
	input  wire logic signed [15:0] analog_ref_code,   // Analog reference
	output logic signed [15:0]      torque_demand,     // Demand, 0.1 %
	output logic signed [15:0]      torque_limit,      // Limit, 0.1 %
	output logic                    demand_valid,      // Demand in use
	output logic                    limit_valid        // Limit in use
);

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic hit(
		input logic [9:0] a,
		input logic [9:0] i
	);
		hit = (a == i);
	endfunction

	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [31:0] dat,
		input logic [3:0]  sel
	);
		merge = old;
		if (sel[0]) begin
			merge[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			merge[15:8] = dat[15:8];
		end
	endfunction

	function automatic logic [15:0] clamp_u(
		input logic [15:0] v,
		input logic [15:0] mx
	);
		clamp_u = (v > mx) ? mx : v;
	endfunction

	function automatic logic [15:0] clamp_s(
		input logic [15:0] v,
		input logic [15:0] mx
	);
		logic signed [15:0] sv;
		logic signed [15:0] smx;
		sv  = $signed(v);
		smx = $signed(mx);
		if (sv > smx) begin
			clamp_s = mx;
		end else if (sv < -smx) begin
			clamp_s = 16'(-smx);
		end else begin
			clamp_s = v;
		end
	endfunction

	function automatic logic is_torque(input tcs_mode_type m);
		is_torque = (m == TCS_ANALOG_TORQUE) || (m == TCS_ZERO_TORQUE);
	endfunction

	// ********************************************************
	// Declarations
	// ********************************************************
	logic [9:0]               idx;
	logic                     req;
	logic                     wr;
	logic                     ack_r;
	logic [31:0]              dat_r;
	logic [31:0]              rd_data;
	tcs_mode_type             mode_r;
	logic [15:0]              mode_w;
	logic [15:0]              smooth_r;
	logic [15:0]              fscale_r;
	logic [15:0]              preset_r [0:`TCS_NUM_PRESET-1];
	logic [15:0]              status;
	logic [`TCS_TICK_W-1:0]   tick_cnt_r;
	logic                     tick_r;
	logic [1:0]               sel_now;
	logic [1:0]               sel_prev_r;
	logic [1:0]               sel_held_r;
	logic signed [31:0]       ana_prod;
	logic signed [15:0]       ana_cmd;
	logic                     filt_on;
	logic signed [31:0]       x_q16;
	logic signed [31:0]       y_r;
	logic signed [32:0]       f_diff;
	logic signed [63:0]       f_prod;
	logic signed [31:0]       f_step;
	logic signed [15:0]       filt_out;
	tcs_div_type              div_st_r;
	logic [15:0]              tau_used_r;
	logic [16:0]              d_r;
	logic [16:0]              num_r;
	logic [16:0]              q_r;
	logic [16:0]              k_r;
	logic [17:0]              rem_r;
	logic [17:0]              rem_sh;
	logic                     ge;
	logic [4:0]               div_cnt_r;
	tcs_src_type              src_nxt;
	tcs_src_type              src_r;
	logic signed [15:0]       cmd_nxt;
	logic signed [15:0]       cmd_r;

	// ********************************************************
	// Bus slave
	// ********************************************************
	assign idx      = wb_adr_i[11:2];
	assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
	// Write lands at the edge where the master samples ack high
	assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign mode_w   = merge({13'h0000, mode_r}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= req;
			if (req) begin
				dat_r <= rd_data;
			end
		end
	end

	always_comb begin
		rd_data = 32'h00000000;
		if (hit(idx, `TCS_IDX_MODE)) begin
			rd_data[2:0] = mode_r;
		end
		if (hit(idx, `TCS_IDX_SMOOTH)) begin
			rd_data[15:0] = smooth_r;
		end
		if (hit(idx, `TCS_IDX_FSCALE)) begin
			rd_data[15:0] = fscale_r;
		end
		for (int i = 0; i < `TCS_NUM_PRESET; i++) begin
			if (hit(idx, `TCS_IDX_PRE1 + 10'(i))) begin
				rd_data[15:0] = preset_r[i];
			end
		end
		if (hit(idx, `TCS_IDX_STATUS)) begin
			rd_data[15:0] = status;
		end
		if (hit(idx, `TCS_IDX_CMD)) begin
			rd_data[15:0] = cmd_r;
		end
	end

	// ********************************************************
	// Configuration registers
	// ********************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_r <= TCS_ANALOG_TORQUE;
		end else if (wr && hit(idx, `TCS_IDX_MODE)) begin
			// Undefined mode codes are dropped
			if (mode_w[2:0] <= TCS_ZERO_TORQUE && mode_w[15:3] == 13'h0000) begin
				mode_r <= tcs_mode_type'(mode_w[2:0]);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			smooth_r <= `TCS_RST_SMOOTH;
		end else if (wr && hit(idx, `TCS_IDX_SMOOTH)) begin
			smooth_r <= clamp_u(merge(smooth_r, wb_dat_i, wb_sel_i),
			                    `TCS_SMOOTH_MAX);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fscale_r <= `TCS_RST_FSCALE;
		end else if (wr && hit(idx, `TCS_IDX_FSCALE)) begin
			fscale_r <= clamp_u(merge(fscale_r, wb_dat_i, wb_sel_i),
			                    `TCS_FSCALE_MAX);
		end
	end

	for (genvar gi = 0; gi < `TCS_NUM_PRESET; gi++) begin : g_pre
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				preset_r[gi] <= `TCS_RST_PRESET;
			end else if (wr && hit(idx, `TCS_IDX_PRE1 + 10'(gi))) begin
				preset_r[gi] <= clamp_s(
					merge(preset_r[gi], wb_dat_i, wb_sel_i),
					`TCS_PRESET_MAX);
			end
		end
	end

	// ********************************************************
	// Sample period
	// ********************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == `TCS_TICK_W'(`TCS_SAMPLE_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// ********************************************************
	// Select inputs
	// ********************************************************
	// one means on
	assign sel_now = {torque_select_bit1, torque_select_bit0};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_prev_r <= 2'h0;
			sel_held_r <= 2'h0;
		end else if (tick_r) begin
			sel_prev_r <= sel_now;
			if (sel_now != sel_prev_r) begin
				sel_held_r <= sel_now;
			end
		end
	end

	// ********************************************************
	// Analog scaling and smoothing
	// ********************************************************
	// voltage times scale
	assign ana_prod = 32'(analog_ref_code) * $signed({16'h0000, fscale_r})
	                  * `TCS_TQ_UNIT;
	assign ana_cmd  = 16'(ana_prod >>> `TCS_ADC_SHIFT);

	assign filt_on  = (mode_r == TCS_ANALOG_TORQUE) &&
	                  (smooth_r != 16'h0000);
	assign x_q16    = 32'(ana_cmd) <<< `TCS_FRAC;
	assign f_diff   = 33'(x_q16) - 33'(y_r);
	assign f_prod   = 64'(f_diff) * 64'($signed({15'h0000, k_r}));
	assign f_step   = 32'(f_prod >>> `TCS_FRAC);
	assign filt_out = 16'(y_r >>> `TCS_FRAC);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			y_r <= 32'sh00000000;
		end else if (tick_r) begin
			if (filt_on) begin
				y_r <= y_r + f_step;
			end else begin
				y_r <= x_q16;
			end
		end
	end

	// ********************************************************
	// Coefficient divider
	// ********************************************************
	assign rem_sh = {rem_r[16:0], num_r[16]};
	assign ge     = (rem_sh >= {1'b0, d_r});

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_st_r   <= TCS_DIV_IDLE;
			tau_used_r <= `TCS_RST_SMOOTH;
			d_r        <= 17'h00001;
			num_r      <= 17'h00000;
			q_r        <= 17'h00000;
			rem_r      <= 18'h00000;
			div_cnt_r  <= 5'h00;
			k_r        <= `TCS_COEF_ONE;
		end else begin
			case (div_st_r)
				TCS_DIV_IDLE: begin
					if (smooth_r != tau_used_r) begin
						tau_used_r <= smooth_r;
						d_r        <= 17'(32'(smooth_r) * `TCS_SMP_PER_MS + 1);
						num_r      <= `TCS_COEF_ONE;
						q_r        <= 17'h00000;
						rem_r      <= 18'h00000;
						div_cnt_r  <= `TCS_DIV_STEPS;
						div_st_r   <= TCS_DIV_RUN;
					end
				end
				TCS_DIV_RUN: begin
					rem_r     <= ge ? rem_sh - {1'b0, d_r} : rem_sh;
					q_r       <= {q_r[15:0], ge};
					num_r     <= {num_r[15:0], 1'b0};
					div_cnt_r <= div_cnt_r - 1'b1;
					if (div_cnt_r == 5'h00) begin
						div_st_r <= TCS_DIV_DONE;
					end
				end
				TCS_DIV_DONE: begin
					k_r      <= q_r;
					div_st_r <= TCS_DIV_IDLE;
				end
				default: begin
					div_st_r <= TCS_DIV_IDLE;
				end
			endcase
		end
	end

	// ********************************************************
	// Command selection
	// ********************************************************
	always_comb begin
		src_nxt = TCS_SRC_ANALOG;
		cmd_nxt = filt_out;
		if (sel_held_r != 2'h0) begin
			src_nxt = TCS_SRC_PRESET;
			cmd_nxt = 16'(32'($signed(preset_r[sel_held_r - 2'h1]))
			              * `TCS_TQ_UNIT);
		end else if (mode_r == TCS_ZERO_TORQUE) begin
			src_nxt = TCS_SRC_ZERO;
			cmd_nxt = 16'sh0000;
		end else begin
			src_nxt = TCS_SRC_ANALOG;
			cmd_nxt = filt_out;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_r <= 16'sh0000;
			src_r <= TCS_SRC_ANALOG;
		end else if (tick_r) begin
			cmd_r <= cmd_nxt;
			src_r <= src_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			torque_demand <= 16'sh0000;
			torque_limit  <= 16'sh0000;
			demand_valid  <= 1'b0;
			limit_valid   <= 1'b0;
		end else if (tick_r) begin
			if (is_torque(mode_r)) begin
				torque_demand <= cmd_nxt;
				torque_limit  <= 16'sh0000;
				demand_valid  <= 1'b1;
				limit_valid   <= 1'b0;
			end else begin
				torque_demand <= 16'sh0000;
				torque_limit  <= cmd_nxt;
				demand_valid  <= 1'b0;
				limit_valid   <= 1'b1;
			end
		end
	end

	// ********************************************************
	// Status
	// ********************************************************
	always_comb begin
		status = 16'h0000;
		status[`TCS_ST_HELD_LSB +: 2] = sel_held_r;
		status[`TCS_ST_SRC_LSB +: 3]  = src_r;
		status[`TCS_ST_FILT]          = filt_on;
		status[`TCS_ST_BUSY]          = (div_st_r != TCS_DIV_IDLE);
		status[`TCS_ST_TORQ]          = is_torque(mode_r);
	end

endmodule

`default_nettype wire

// ==== verification/tcs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module tcs_monitor (
	input wire logic               clk,          // Clock
	input wire logic               rst,          // Async reset
	input wire logic               wb_cyc_i,     // Bus cycle
	input wire logic               wb_stb_i,     // Bus strobe
	input wire logic               wb_we_i,      // Write enable
	input wire logic [11:0]        wb_adr_i,     // Byte address
	input wire logic [31:0]        wb_dat_o,     // Read data
	input wire logic               wb_ack_o,     // Acknowledge
	input wire logic signed [15:0] torque_demand, // Demand
	input wire logic               demand_valid, // Demand in use
	input wire logic               limit_valid   // Limit in use
);
	logic        [12:0] up_r;
	logic        [12:0] gap_r;
	logic signed [15:0] dq_r;
	logic               rd_ack;

	assign rd_ack = wb_ack_o && !wb_we_i;

	// ****************************************
	// Cycle counters
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			up_r <= 13'h0000;
		else if (up_r != 13'h1FFF)
			up_r <= up_r + 13'h0001;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_r <= 13'h0000;
			dq_r  <= 16'sh0000;
		end else begin
			dq_r <= torque_demand;
			if (torque_demand != dq_r)
				gap_r <= 13'h0001;
			else if (gap_r != 13'h1FFF)
				gap_r <= gap_r + 13'h0001;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_on_request: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_needs_req: assert property (
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_valid_exclusive: assert property (
		!(demand_valid && limit_valid))
		else $error("demand and limit both in use");
	a_quiet_start: assert property (
		up_r < 13'h04B0 |-> torque_demand == 16'sh0000 && !demand_valid)
		else $error("output before first sample");
	a_valid_after_tick: assert property (
		up_r == 13'h0600 |-> demand_valid || limit_valid)
		else $error("no output in use after first sample");
	a_output_per_sample: assert property (
		torque_demand != dq_r |-> gap_r >= 13'h04B0)
		else $error("demand changed between samples");
	a_read_upper_zero: assert property (
		rd_ack |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_scale_in_range: assert property (
		rd_ack && wb_adr_i == 12'h4A4 |-> wb_dat_o[15:0] <= 16'h03E8)
		else $error("scaling above range");
	a_smooth_in_range: assert property (
		rd_ack && wb_adr_i == 12'h438 |-> wb_dat_o[15:0] <= 16'h03E8)
		else $error("smoothing above range");
	a_preset_span: assert property (
		rd_ack && wb_adr_i >= 12'h404 && wb_adr_i <= 12'h40C
		|-> $signed(wb_dat_o[15:0]) >= -16'sh012C
		&& $signed(wb_dat_o[15:0]) <= 16'sh012C)
		else $error("preset outside span");

	c_limit_used: cover property ($rose(limit_valid));
	c_negative_demand: cover property (demand_valid && torque_demand < 0);
	c_preset_read: cover property (rd_ack && wb_adr_i == 12'h40C);
endmodule

bind tcs_top tcs_monitor u_mon (
	.clk          (clk),
	.rst          (rst),
	.wb_cyc_i     (wb_cyc_i),
	.wb_stb_i     (wb_stb_i),
	.wb_we_i      (wb_we_i),
	.wb_adr_i     (wb_adr_i),
	.wb_dat_o     (wb_dat_o),
	.wb_ack_o     (wb_ack_o),
	.torque_demand(torque_demand),
	.demand_valid (demand_valid),
	.limit_valid  (limit_valid)
);

`default_nettype wire

// ==== verification/tcs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_host_model (
	input  wire logic               clk,                // Clock
	input  wire logic               rst,                // Async reset
	input  wire logic [1:0]         req_pat,            // Wanted pattern
	input  wire logic signed [15:0] req_code,           // Wanted reference
	input  wire logic               slow,               // Late answer
	output logic                    torque_select_bit0, // Select 0
	output logic                    torque_select_bit1, // Select 1
	output logic signed [15:0]      analog_ref_code     // Reference
);
	logic [11:0] hold_r;
	logic [8:0]  dly_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_r             <= 12'h000;
			dly_r              <= 9'h000;
			torque_select_bit0 <= 1'b0;
			torque_select_bit1 <= 1'b0;
			analog_ref_code    <= 16'sh0000;
		end else if (hold_r != 12'h000) begin
			hold_r <= hold_r - 12'h001;
		end else if ({torque_select_bit1, torque_select_bit0} != req_pat
			|| analog_ref_code != req_code) begin
			if (slow && dly_r != 9'h12C) begin
				dly_r <= dly_r + 9'h001;
			end else begin
				torque_select_bit0 <= req_pat[0];
				torque_select_bit1 <= req_pat[1];
				analog_ref_code    <= req_code;
				hold_r             <= 12'(`TCS_SAMPLE_CYC);
				dly_r              <= 9'h000;
			end
		end
	end
endmodule

`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcs_cfg.svh"

module tb_top;
	logic               clk, rst, cyc, stb, we, ack, b0, b1, dv, lv;
	logic               slow, smp;
	logic [11:0]        adr;
	logic [31:0]        dat, rdat, lfsr, e;
	logic [3:0]         sel;
	logic [1:0]         pat;
	logic signed [15:0] code, acode, dmd, lim, s, v;
	logic signed [15:0] pre [1:3];
	logic [31:0]        exp_q [$];
	int                 fails, n_tests;

	tcs_top u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .torque_select_bit0(b0),
		.torque_select_bit1(b1), .analog_ref_code(acode),
		.torque_demand(dmd), .torque_limit(lim), .demand_valid(dv),
		.limit_valid(lv));

	tcs_host_model u_host (.clk(clk), .rst(rst), .req_pat(pat),
		.req_code(code), .slow(slow), .torque_select_bit0(b0),
		.torque_select_bit1(b1), .analog_ref_code(acode));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic end_of_test;
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (i == 16) begin
			fails++;
			end_of_test();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		wb(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] lfsr_nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [31:0] ex(input logic d,
		input logic signed [15:0] v);
		return {d, ~d, 14'h0, v};
	endfunction

	function automatic logic signed [15:0] ana(input logic signed [15:0] c,
		input logic signed [15:0] sc);
		int p;
		p = c * sc * 10;
		return 16'(p >>> 15);
	endfunction

	task automatic tq(input logic [1:0] p, input logic signed [15:0] c,
		input logic [31:0] want);
		pat <= p;
		code <= c;
		repeat (`TCS_SAMPLE_CYC * 3) @(posedge clk);
		exp_q.push_back(want);
		smp <= 1'b1;
		@(posedge clk);
		smp <= 1'b0;
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	always @(posedge clk) begin
		if ((ack === 1'b1 && !we) || smp) begin
			e = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
			if (smp)
				chk({dv, lv, 14'h0, dv ? dmd : lim}, e);
			else
				chk(rdat, e);
		end
	end

	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		end_of_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, cyc, stb, we, slow, smp} = 6'h20;
		adr = 12'h000;
		dat = 32'h0;
		sel = 4'h0;
		pat = 2'h0;
		code = 16'sh0000;
		lfsr = 32'h7CC55A1C;
		pre = '{16'sh0064, 16'shFF38, 16'sh012C};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(12'h438, 32'h0);
		rd(12'h4A4, 32'h64);
		rd(12'h5FC, 32'h0);
		tq(2'h0, 16'sh4000, ex(1'b1, 16'sh01F4));
		wb(1'b1, 12'h4A4, 32'h0000FFFF);
		rd(12'h4A4, 32'h3E8);
		tq(2'h0, 16'sh7FFF, ex(1'b1, ana(16'sh7FFF, 16'sh03E8)));
		wb(1'b1, 12'h4A4, 32'h64);
		wb(1'b1, 12'h400, 32'h5);
		tq(2'h0, 16'sh4000, ex(1'b1, 16'sh0000));
		wb(1'b1, 12'h404, 32'h64);
		wb(1'b1, 12'h408, 32'hFF38);
		wb(1'b1, 12'h40C, 32'h190);
		rd(12'h40C, 32'h12C);
		for (int p = 1; p <= 3; p++)
			tq(2'(p), 16'sh4000, ex(1'b1, 16'(pre[p] * 16'sh000A)));
		wb(1'b1, 12'h438, 32'h7D0);
		rd(12'h438, 32'h3E8);
		wb(1'b1, 12'h438, 32'h5);
		wb(1'b1, 12'h400, 32'h2);
		tq(2'h2, 16'sh4000, ex(1'b0, 16'shF830));
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, 12'h400, 32'(m));
			tq(2'h0, 16'sh4000, ex(1'b0, 16'sh01F4));
		end
		wb(1'b1, 12'h400, 32'h4);
		code <= 16'sh0000;
		repeat (`TCS_SAMPLE_CYC * 3) @(posedge clk);
		chk({31'h0, dv && dmd > 0 && dmd < 16'sh01F4}, 32'h1);
		wb(1'b1, 12'h438, 32'h0);
		tq(2'h0, 16'sh0000, ex(1'b1, 16'sh0000));
		slow <= 1'b1;
		repeat (3) begin
			lfsr = lfsr_nx(lfsr);
			s = lfsr[9:0] > 10'h3E8 ? 16'sh03E8 : 16'(lfsr[9:0]);
			v = ana(lfsr[31:16], s);
			wb(1'b1, 12'h4A4, 32'(s));
			tq(2'h0, lfsr[31:16], ex(1'b1, v));
			rd(12'h4C4, {16'h0000, v});
		end
		wb(1'b1, 12'h400, 32'h7);
		rd(12'h400, 32'h4);
		rd(12'h4C0, 32'h88);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule

`default_nettype wire
